/* File: temp_readout_pkg.sv */
// shared constants and carrier types for the temperature readout block
package temp_readout_pkg;
  localparam int NUM_CH = 9;
  localparam int RES_W = 16;
  localparam int ADDR_W = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_RESULT0 = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CONFIG = 8'h40;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h44;
  localparam logic [ADDR_W-1:0] OFF_HYST = 8'h48;
  localparam logic [ADDR_W-1:0] OFF_LIMIT1 = 8'h50;
  localparam logic [ADDR_W-1:0] OFF_LIMIT2 = 8'h80;
  localparam logic [ADDR_W-1:0] OFF_ALERT = 8'h4C;

  // configuration fields
  localparam int CFG_PD_BIT = 5;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [RES_W-1:0] HYST_RESET = 16'h0500;
  localparam logic [RES_W-1:0] LIMIT1_RESET = 16'h5500;
  localparam logic [RES_W-1:0] LIMIT2_RESET = 16'h5500;

  // result format: 13 significant bits left-justified over 3 zero bits
  localparam int FRAC_ZERO_W = 3;
  localparam logic [RES_W-1:0] RESULT_MIN = 16'h8000;

  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int CONV_PER_S = 16;
  localparam int CYCLE_COUNT = CLK_HZ / CONV_PER_S;

  // one diode sample delivered by the analog front end
  typedef struct packed {
    logic valid;
    logic [3:0] channel;
    logic [12:0] code;
    logic shorted;
    logic fault_cmp;
  } sample_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;
endpackage : temp_readout_pkg

/* File: multi_channel_temp_readout.sv */
// digital readout of a nine-channel temperature monitor with apb registers
`timescale 1ns/1ns
// Behaviour
// - convert local plus eight remote channels, one result each
// - results carry 13 bits at one sixteenth degree per count
// - results left-justified in 16 bits, low three bits zero, two's complement
// - encoding spans 255.9375 down to -256 degrees
// - upper byte two degrees per count, low byte the one-degree bit plus the fraction
// - shorted remote diode reports -256 degrees
// - fault comparator watched throughout every remote conversion
// - detected remote fault sets that channel's open-fault flag
// - two alert outputs from comparing results with limit registers
// - one hysteresis register applies to both alert outputs
// - power-down bit set: finish current conversion cycle through the last channel then stop
// - in power-down only the register interface keeps working
// - power-down bit low: a new conversion cycle starts once every cycle timer period
// - conversion rate after reset is 16 cycles per second
module multi_channel_temp_readout
  import temp_readout_pkg::*;
#(
  parameter int CYCLE_CLKS = CYCLE_COUNT
)
(
  input wire logic mclk,
  input wire logic rstn,
  input wire apb_req_type apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sample_type sample,
  output logic [3:0] conv_channel,
  output logic conv_start,
  output logic primary_overtemp_alert,
  output logic secondary_overtemp_alert
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_WAIT = 3'b100
  } conv_state_type;

  // apb state
  logic [7:0] config_r, config_nxt;
  logic [RES_W-1:0] hyst_r, hyst_nxt;
  logic [RES_W-1:0] lim1_r [NUM_CH];
  logic [RES_W-1:0] lim1_nxt [NUM_CH];
  logic [RES_W-1:0] lim2_r [NUM_CH];
  logic [RES_W-1:0] lim2_nxt [NUM_CH];
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;

  // conversion state
  conv_state_type state_r, state_nxt;
  logic [3:0] chan_r, chan_nxt;
  logic [31:0] tick_r, tick_nxt;
  logic start_r, start_nxt;
  logic fault_seen_r, fault_seen_nxt;
  logic [RES_W-1:0] result_r [NUM_CH];
  logic [RES_W-1:0] result_nxt [NUM_CH];
  logic [NUM_CH-1:0] open_r, open_nxt;
  logic [NUM_CH-1:0] alert1_r, alert1_nxt;
  logic [NUM_CH-1:0] alert2_r, alert2_nxt;
  logic out1_r, out1_nxt;
  logic out2_r, out2_nxt;

  logic power_down_bit;
  logic sample_done;
  logic access;
  logic [ADDR_W-1:0] idx_addr;

  assign power_down_bit = config_r[CFG_PD_BIT];
  assign sample_done = sample.valid && (state_r == ST_CONV)
                       && (sample.channel == chan_r);
  assign access = apb_req.psel && apb_req.penable && !pready_r;
  assign idx_addr = apb_req.paddr;

  // signed compare helper
  function automatic logic above(input logic [RES_W-1:0] a,
                                 input logic [RES_W-1:0] b);
    above = $signed(a) > $signed(b);
  endfunction : above

  // apb slave: one wait state, answer in the cycle after the first access cycle
  always_comb
  begin
    config_nxt = config_r;
    hyst_nxt = hyst_r;
    lim1_nxt = lim1_r;
    lim2_nxt = lim2_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    pready_nxt = access;
    if (access)
    begin
      prdata_nxt = 32'h00000000;
      pslverr_nxt = 1'b1;
      for (int i = 0; i < NUM_CH; i++)
      begin
        if (idx_addr == OFF_RESULT0 + 8'(4 * i))
        begin
          prdata_nxt = {16'h0000, result_r[i]};
          pslverr_nxt = apb_req.pwrite; // results are read-only
        end
        if (idx_addr == OFF_LIMIT1 + 8'(4 * i))
        begin
          pslverr_nxt = 1'b0;
          prdata_nxt = {16'h0000, lim1_r[i]};
          if (apb_req.pwrite)
            lim1_nxt[i] = {apb_req.pwdata[RES_W-1:FRAC_ZERO_W],
                           FRAC_ZERO_W'(0)};
        end
        if (idx_addr == OFF_LIMIT2 + 8'(4 * i))
        begin
          pslverr_nxt = 1'b0;
          prdata_nxt = {16'h0000, lim2_r[i]};
          if (apb_req.pwrite)
            lim2_nxt[i] = {apb_req.pwdata[RES_W-1:FRAC_ZERO_W],
                           FRAC_ZERO_W'(0)};
        end
      end
      unique case (idx_addr)
        OFF_CONFIG:
        begin
          pslverr_nxt = 1'b0;
          prdata_nxt = {24'h000000, config_r};
          if (apb_req.pwrite)
            config_nxt = apb_req.pwdata[7:0];
        end
        OFF_STATUS:
        begin
          pslverr_nxt = apb_req.pwrite;
          prdata_nxt = {23'h000000, open_r};
        end
        OFF_HYST:
        begin
          pslverr_nxt = 1'b0;
          prdata_nxt = {16'h0000, hyst_r};
          if (apb_req.pwrite)
            hyst_nxt = {apb_req.pwdata[RES_W-1:FRAC_ZERO_W],
                        FRAC_ZERO_W'(0)};
        end
        OFF_ALERT:
        begin
          pslverr_nxt = apb_req.pwrite;
          prdata_nxt = {5'h00, alert2_r, 9'h000, alert1_r};
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      config_r <= CFG_RESET;
      hyst_r <= HYST_RESET;
      for (int i = 0; i < NUM_CH; i++)
      begin
        lim1_r[i] <= LIMIT1_RESET;
        lim2_r[i] <= LIMIT2_RESET;
      end
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      config_r <= config_nxt;
      hyst_r <= hyst_nxt;
      lim1_r <= lim1_nxt;
      lim2_r <= lim2_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // conversion sequencer; the cycle timer keeps 16 cycles per second
  // even when the front end finishes early, so the rate stays fixed
  always_comb
  begin
    state_nxt = state_r;
    chan_nxt = chan_r;
    start_nxt = 1'b0;
    fault_seen_nxt = fault_seen_r;
    result_nxt = result_r;
    open_nxt = open_r;
    tick_nxt = (tick_r == 32'(CYCLE_CLKS - 1)) ? 32'h00000000
                                               : tick_r + 32'h00000001;
    if (state_r == ST_IDLE && power_down_bit)
      tick_nxt = 32'h00000000;
    unique case (state_r)
      ST_IDLE:
      begin
        if (!power_down_bit)
        begin
          state_nxt = ST_CONV;
          chan_nxt = 4'h0;
          start_nxt = 1'b1;
          fault_seen_nxt = 1'b0;
          tick_nxt = 32'h00000000; // full period from this start
        end
      end
      ST_CONV:
      begin
        if (chan_r != 4'h0 && sample.fault_cmp)
          fault_seen_nxt = 1'b1;
        if (sample_done)
        begin
          if (chan_r != 4'h0 && sample.shorted)
            result_nxt[chan_r] = RESULT_MIN;
          else
            result_nxt[chan_r] = {sample.code, FRAC_ZERO_W'(0)};
          if (chan_r != 4'h0)
            open_nxt[chan_r] = fault_seen_r || sample.fault_cmp;
          fault_seen_nxt = 1'b0;
          if (chan_r == 4'(NUM_CH - 1))
            state_nxt = ST_WAIT;
          else
          begin
            chan_nxt = chan_r + 4'h1;
            start_nxt = 1'b1;
          end
        end
      end
      // power-down stops at once after the last channel, not at the tick
      ST_WAIT:
      begin
        if (power_down_bit)
          state_nxt = ST_IDLE;
        else if (tick_r == 32'(CYCLE_CLKS - 1))
        begin
          state_nxt = ST_CONV;
          chan_nxt = 4'h0;
          start_nxt = 1'b1;
        end
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // alert decision with shared hysteresis
  always_comb
  begin
    alert1_nxt = alert1_r;
    alert2_nxt = alert2_r;
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (above(result_r[i], lim1_r[i]))
        alert1_nxt[i] = 1'b1;
      else if (above(lim1_r[i] - hyst_r, result_r[i]))
        alert1_nxt[i] = 1'b0;
      if (above(result_r[i], lim2_r[i]))
        alert2_nxt[i] = 1'b1;
      else if (above(lim2_r[i] - hyst_r, result_r[i]))
        alert2_nxt[i] = 1'b0;
    end
    if (state_r == ST_IDLE && power_down_bit)
    begin
      alert1_nxt = alert1_r; // frozen while powered down
      alert2_nxt = alert2_r;
    end
    out1_nxt = |alert1_nxt;
    out2_nxt = |alert2_nxt;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= ST_IDLE;
      chan_r <= 4'h0;
      tick_r <= 32'h00000000;
      start_r <= 1'b0;
      fault_seen_r <= 1'b0;
      for (int i = 0; i < NUM_CH; i++)
        result_r[i] <= 16'h0000;
      open_r <= '0;
      alert1_r <= '0;
      alert2_r <= '0;
      out1_r <= 1'b0;
      out2_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      chan_r <= chan_nxt;
      tick_r <= tick_nxt;
      start_r <= start_nxt;
      fault_seen_r <= fault_seen_nxt;
      result_r <= result_nxt;
      open_r <= open_nxt;
      alert1_r <= alert1_nxt;
      alert2_r <= alert2_nxt;
      out1_r <= out1_nxt;
      out2_r <= out2_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign conv_channel = chan_r;
  assign conv_start = start_r;
  assign primary_overtemp_alert = out1_r;
  assign secondary_overtemp_alert = out2_r;

endmodule : multi_channel_temp_readout

/* File: front_end_model.sv */
// behavioural analog front end answering conversion requests
`timescale 1ns/1ns
module front_end_model
  import temp_readout_pkg::*;
(
  input wire logic mclk,
  input wire logic conv_start,
  input wire logic [3:0] conv_channel,
  input wire logic [12:0] code,
  input wire logic [3:0] short_ch,
  input wire logic [3:0] fault_ch,
  input wire logic slow,
  output sample_type sample
);
  int cnt = -1;
  logic [3:0] ch = 4'h0;
  initial sample = '0;
  // idle code toggles so a stale word never passes for a result
  always @(posedge mclk)
  begin
    sample.valid <= 1'b0;
    sample.code <= ~sample.code;
    // comparator trips mid-conversion only; a check at the end alone misses it
    sample.fault_cmp <= cnt > 0 && ch == fault_ch;
    if (conv_start)
    begin
      ch <= conv_channel;
      cnt <= slow ? 12 : 2;
    end
    else if (cnt > 0)
      cnt <= cnt - 1;
    else if (cnt == 0)
    begin
      cnt <= -1;
      sample.valid <= 1'b1;
      sample.channel <= ch;
      sample.code <= code;
      sample.shorted <= ch == short_ch;
    end
  end
endmodule : front_end_model

/* File: temp_readout_props.sv */
// port assertions for the temperature readout block
`timescale 1ns/1ns
module temp_readout_props
  import temp_readout_pkg::*;
#(
  parameter int CYCLE_CLKS = CYCLE_COUNT
)
(
  input wire logic mclk,
  input wire logic rstn,
  input wire apb_req_type apb_req,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire sample_type sample,
  input wire logic [3:0] conv_channel,
  input wire logic conv_start,
  input wire logic primary_overtemp_alert,
  input wire logic secondary_overtemp_alert
);
  logic pd_r;
  logic pd_nxt;
  wire logic ev = sample.valid || pready;
  // copy of the power-down bit as written over the bus
  always_comb
  begin
    pd_nxt = pd_r;
    if (pready && apb_req.pwrite && apb_req.paddr == OFF_CONFIG)
      pd_nxt = apb_req.pwdata[CFG_PD_BIT];
  end
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn)
      pd_r <= 1'b0;
    else
      pd_r <= pd_nxt;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  sequence access_s;
    apb_req.psel && apb_req.penable && !pready;
  endsequence
  sequence done_s;
    sample.valid && sample.channel == conv_channel;
  endsequence
  wait_one_a: assert property (access_s |=> pready)
    else $error("no answer after one wait");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  result_fmt_a: assert property (pready && !apb_req.pwrite
    && apb_req.paddr < 8'h24 |-> prdata[31:16] == 16'h0 && prdata[2:0] == 3'h0)
    else $error("result word badly formed");
  result_ro_a: assert property (access_s ##0 (apb_req.pwrite
    && apb_req.paddr < 8'h24) |=> pslverr)
    else $error("result write accepted");
  next_chan_a: assert property (done_s ##0 conv_channel != 4'h8
    |=> conv_start && conv_channel == $past(conv_channel) + 4'h1)
    else $error("next channel not started");
  pd_stop_a: assert property (conv_start && conv_channel == 4'h0
    |-> !pd_r)
    else $error("cycle started in power-down");
  alert_one_a: assert property ($changed(primary_overtemp_alert)
    |-> $past(ev) || $past(ev, 2) || $past(ev, 3))
    else $error("primary alert moved without cause");
  alert_two_a: assert property ($changed(secondary_overtemp_alert)
    |-> $past(ev) || $past(ev, 2) || $past(ev, 3))
    else $error("secondary alert moved without cause");
endmodule : temp_readout_props
bind multi_channel_temp_readout temp_readout_props #(.CYCLE_CLKS(CYCLE_CLKS))
  props (.mclk, .rstn, .apb_req, .prdata, .pready, .pslverr, .sample,
  .conv_channel, .conv_start, .primary_overtemp_alert,
  .secondary_overtemp_alert);

/* File: multi_channel_temp_readout_tb_top.sv */
// self-checking bench for the temperature readout block
`timescale 1ns/1ns
module multi_channel_temp_readout_tb_top
  import temp_readout_pkg::*;
;
  localparam int CLKS = 200;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic slow = 1'b0;
  logic [3:0] short_ch = 4'hF;
  logic [3:0] fault_ch = 4'hF;
  logic [12:0] code = 13'h0000;
  apb_req_type req = '0;
  sample_type sample;
  logic [31:0] prdata;
  logic pready, pslverr, conv_start, al1, al2;
  logic [3:0] conv_channel;
  int fail_count = 0;
  int compares = 0;
  always #5 mclk = ~mclk;
  multi_channel_temp_readout #(.CYCLE_CLKS(CLKS)) dut (.mclk, .rstn,
    .apb_req(req), .prdata, .pready, .pslverr, .sample, .conv_channel,
    .conv_start, .primary_overtemp_alert(al1),
    .secondary_overtemp_alert(al2));
  front_end_model fe (.mclk, .conv_start, .conv_channel, .code, .short_ch,
    .fault_ch, .slow, .sample);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("%0d compares, %0d mismatches", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  // one apb transfer; d is the expected word on a read
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic e);
    int n;
    n = 0;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge mclk);
    req.penable <= 1'b1;
    do
      @(posedge mclk);
    while (pready !== 1'b1 && ++n < 20);
    check(pready, 32'h1);
    if (pready !== 1'b1)
      end_sim();
    check(pslverr, e);
    if (!w)
      check(prdata, d);
    req <= '0;
    @(posedge mclk);
  endtask : acc
  task automatic t_regs;
    acc(1'b0, OFF_CONFIG, 32'h0, 1'b0);
    acc(1'b0, OFF_HYST, 32'h0500, 1'b0);
    acc(1'b0, OFF_LIMIT2 + 8'h20, 32'h5500, 1'b0);
    acc(1'b0, 8'hFC, 32'h0, 1'b1);
    $display("regs done");
  endtask : t_regs
  task automatic t_fmt;
    logic [12:0] tc [3] = '{13'h0FFF, 13'h1000, 13'h0190};
    logic [31:0] want;
    short_ch <= 4'h3;
    fault_ch <= 4'h5;
    slow <= 1'b1;
    foreach (tc[i])
    begin
      code <= tc[i];
      repeat (2 * CLKS) @(posedge mclk);
      // channel 3 is shorted, every other one reports the code
      for (int c = 0; c < NUM_CH; c++)
      begin
        want = (c == 3) ? 32'(RESULT_MIN) : 32'({tc[i], 3'h0});
        acc(1'b0, 8'(4 * c), want, 1'b0);
      end
    end
    acc(1'b0, OFF_STATUS, 32'h20, 1'b0);
    acc(1'b1, OFF_RESULT0, 32'h0, 1'b1);
    acc(1'b0, OFF_RESULT0, 32'h0C80, 1'b0);
    $display("format done");
  endtask : t_fmt
  task automatic t_alert;
    short_ch <= 4'hF;
    fault_ch <= 4'hF;
    slow <= 1'b0;
    acc(1'b1, OFF_LIMIT1, 32'h0A00, 1'b0);
    acc(1'b1, OFF_LIMIT2 + 8'h08, 32'h0A00, 1'b0);
    repeat (2 * CLKS) @(posedge mclk);
    check({al1, al2}, 32'h3);
    acc(1'b0, OFF_ALERT, 32'h00100001, 1'b0);
    code <= 13'h00C0; // 12 degrees, inside the band
    repeat (2 * CLKS) @(posedge mclk);
    check({al1, al2}, 32'h3);
    code <= 13'h0050; // 5 degrees, below limit less band
    repeat (2 * CLKS) @(posedge mclk);
    check({al1, al2}, 32'h0);
    acc(1'b0, OFF_STATUS, 32'h0, 1'b0);
    $display("alert done");
  endtask : t_alert
  task automatic t_pd;
    int n;
    n = 0;
    acc(1'b1, OFF_CONFIG, 32'h20, 1'b0);
    repeat (CLKS) @(posedge mclk);
    repeat (2 * CLKS)
    begin
      @(posedge mclk);
      n += (conv_start !== 1'b0);
    end
    check(n, 0);
    acc(1'b0, OFF_CONFIG, 32'h20, 1'b0);
    acc(1'b1, OFF_CONFIG, 32'h0, 1'b0);
    // restart from power-down must keep the full cycle length
    n = 0;
    while (!(conv_start === 1'b1 && conv_channel === 4'h0) && n < 2 * CLKS)
    begin
      @(posedge mclk);
      n++;
    end
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (!(conv_start === 1'b1 && conv_channel === 4'h0) && n < 2 * CLKS);
    check(n, CLKS);
    n = 0;
    repeat (2 * CLKS)
    begin
      @(posedge mclk);
      n += (conv_start === 1'b1);
    end
    check(n >= 9, 32'h1);
    $display("power-down done");
  endtask : t_pd
  initial
  begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    t_regs();
    t_fmt();
    t_alert();
    t_pd();
    end_sim();
  end
endmodule : multi_channel_temp_readout_tb_top
